// ===== monitor_result_alert_regs_tb.sv
// self-checking bench for the register bank with a host model.
// assumes a 40 ns clock and a shortened conversion period of 20 cycles.
`timescale 1ns/1ps

module monitor_result_alert_regs_tb;
	typedef struct {
		logic [7:0]  addr;
		logic [15:0] wdata;
		bit          wide;
		logic [15:0] rexp;
	} mra_tb_row_t;

	logic                    clk_sys_in, resetn_in, xs, wv, rr, rv, cs;
	logic [7:0]              ra, wb, rb, chan;
	logic [15:0]             setup, q;
	logic                    pin_en;
	mra_pkg::mra_sample_t    smp;
	mra_pkg::mra_alert_evt_t evt;
	mra_pkg::mra_levels_t    lv;
	int                      error_cnt, checks, i;
	mra_tb_row_t             rows [4];

	mra_regs #(.CONV_CYCLES(20)) dut (.clk_sys_in(clk_sys_in),
		.resetn_in(resetn_in), .xfer_start_in(xs), .reg_addr_in(ra),
		.wr_byte_valid_in(wv), .wr_byte_in(wb), .rd_byte_req_in(rr),
		.rd_byte_out(rb), .rd_byte_valid_out(rv), .conv_start_out(cs),
		.sample_in(smp), .alert_evt_in(evt), .levels_out(lv),
		.channel_select_out(chan), .setup_out(setup),
		.alert_pin_enable_out(pin_en));
	mra_host_model host (.clk_sys_in(clk_sys_in), .rd_byte_in(rb),
		.rd_valid_in(rv), .xfer_start_out(xs), .reg_addr_out(ra),
		.wr_valid_out(wv), .wr_byte_out(wb), .rd_req_out(rr));

	initial begin
		clk_sys_in = 1'b0;
		forever #20 clk_sys_in = ~clk_sys_in;
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic give_verdict;
		$display("mismatches=%0d comparisons=%0d", error_cnt, checks);
		if (error_cnt == 0 && checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : give_verdict

	// results land one edge after the pulse, so step past it
	task automatic wait_conv;
		int n;
		n = 0;
		while (cs !== 1'b1 && n < 50) begin
			@(posedge clk_sys_in) #1;
			n++;
		end
		if (cs !== 1'b1) begin
			error_cnt++;
			give_verdict();
		end
		@(posedge clk_sys_in) #1;
	endtask : wait_conv

	task automatic pulse_evt(input logic [21:0] e);
		@(posedge clk_sys_in) #1;
		evt = e;
		@(posedge clk_sys_in) #1;
		evt = '0;
	endtask : pulse_evt

	initial begin
		resetn_in = 1'b0;
		smp = '0;
		evt = '0;
		rows[0] = '{8'h09, 16'h1230, 1'b1, 16'h1230};
		rows[1] = '{8'h08, 16'h00FF, 1'b0, 16'h003F};
		rows[2] = '{8'h01, 16'h5678, 1'b1, 16'h0000};
		rows[3] = '{8'h30, 16'h00AA, 1'b0, 16'h0000};
		repeat (20) @(posedge clk_sys_in);
		#1 resetn_in = 1'b1;
		repeat (2) @(posedge clk_sys_in) #1;
		chk(setup, 16'h0000);
		host.rd(8'h09, 1'b1, q);
		chk(q, 16'h0000);
		foreach (rows[k]) begin
			host.wr(rows[k].addr, rows[k].wdata, rows[k].wide);
			host.rd(rows[k].addr, rows[k].wide, q);
			chk(q, rows[k].rexp);
		end
		chk({8'h00, chan}, 16'h003F);
		chk({15'h0000, pin_en}, 16'h0000);
		for (i = 0; i < 4; i++) begin
			host.wr(8'h01 + 8'(i), {4'hF, 12'hA00 + 12'(i)}, 1'b1);
			chk(16'(lv[47 - 12 * i -: 12]), 16'h0A00 + 16'(i));
		end
		host.open_reg(8'h02);
		host.put(8'h11);
		host.open_reg(8'h08);
		chk(16'(lv.level_b), 16'h0A01);
		smp = '{11'h7FF, 11'h400, 11'h001, 1'b1, 1'b0};
		wait_conv();
		host.rd(8'h02, 1'b1, q);
		chk(q, 16'h6FFF);
		host.rd(8'h03, 1'b1, q);
		chk(q, 16'h7400);
		host.rd(8'h04, 1'b1, q);
		chk(q, 16'h0001);
		smp = '{11'h155, 11'h0AA, 11'h7F0, 1'b0, 1'b1};
		wait_conv();
		host.rd(8'h02, 1'b1, q);
		chk(q, 16'h6155);
		host.rd(8'h03, 1'b1, q);
		chk(q, 16'h78AA);
		pulse_evt({8'hA5, 6'h3F, 8'h81});
		wait_conv();
		host.rd(8'h02, 1'b1, q);
		chk(q, 16'hE155);
		host.rd(8'h04, 1'b1, q);
		chk(q, 16'h87F0);
		host.rd(8'h05, 1'b0, q);
		chk(q, 16'h00A5);
		host.rd(8'h06, 1'b0, q);
		chk(q, 16'h003F);
		host.wr(8'h05, 16'h0005, 1'b0);
		host.rd(8'h05, 1'b0, q);
		chk(q, 16'h00A0);
		host.wr(8'h07, 16'h00FF, 1'b0);
		host.rd(8'h07, 1'b0, q);
		chk(q, 16'h0000);
		pulse_evt({8'h00, 6'h00, 8'hC0});
		host.wr(8'h09, 16'h0006, 1'b1);
		chk({15'h0000, pin_en}, 16'h0001);
		chk(setup, 16'h0006);
		for (i = 5; i < 8; i++) begin
			host.rd(8'(i), 1'b0, q);
			chk(q, 16'h0000);
		end
		// a reset in mid-run must bring the setup word back to zero
		@(posedge clk_sys_in) #1 resetn_in = 1'b0;
		@(posedge clk_sys_in) #1 resetn_in = 1'b1;
		chk(setup, 16'h0000);
		give_verdict();
	end
endmodule : monitor_result_alert_regs_tb

// ===== mra_host_model.sv
// host side of the byte strobe register port, driven by bench calls.
// assumes one caller at a time; strobes last one cycle with a gap after.
`timescale 1ns/1ps

module mra_host_model (
	input  wire logic       clk_sys_in,
	input  wire logic [7:0] rd_byte_in,
	input  wire logic       rd_valid_in,
	output logic            xfer_start_out,
	output logic      [7:0] reg_addr_out,
	output logic            wr_valid_out,
	output logic      [7:0] wr_byte_out,
	output logic            rd_req_out
);
	initial begin
		xfer_start_out = 1'b0;
		reg_addr_out = 8'h00;
		wr_valid_out = 1'b0;
		wr_byte_out = 8'h00;
		rd_req_out = 1'b0;
	end

	// released lines show the inverse so stale values never match
	task automatic open_reg(input logic [7:0] a);
		@(posedge clk_sys_in) #1;
		xfer_start_out = 1'b1;
		reg_addr_out = a;
		@(posedge clk_sys_in) #1;
		xfer_start_out = 1'b0;
		reg_addr_out = ~a;
	endtask : open_reg

	task automatic put(input logic [7:0] b);
		@(posedge clk_sys_in) #1;
		wr_valid_out = 1'b1;
		wr_byte_out = b;
		@(posedge clk_sys_in) #1;
		wr_valid_out = 1'b0;
		wr_byte_out = ~b;
	endtask : put

	task automatic get(output logic [7:0] b);
		@(posedge clk_sys_in) #1;
		rd_req_out = 1'b1;
		@(posedge clk_sys_in) #1;
		rd_req_out = 1'b0;
		b = rd_valid_in ? rd_byte_in : 8'hXX;
	endtask : get

	task automatic wr(input logic [7:0] a, input logic [15:0] d,
		input bit wide);
		open_reg(a);
		if (wide) put(d[15:8]);
		put(d[7:0]);
	endtask : wr

	task automatic rd(input logic [7:0] a, input bit wide,
		output logic [15:0] q);
		logic [7:0] b;
		q = 16'h0000;
		open_reg(a);
		if (wide) begin
			get(b);
			q[15:8] = b;
		end
		get(b);
		q[7:0] = b;
	endtask : rd
endmodule : mra_host_model

// ===== mra_pkg.sv
// register bank constants, field layout and carrier types of the monitor.
// assumes one 25 MHz clock shared by the register port and measurement side.
// Summary of operation
// - remote result words are 16-bit read-only; D15 alert flag, D14:D12 tag
// - remote result D11 shows the sensing diode was found open
// - temperature held as 11-bit two's complement in D10 to D0
// - every result refreshed by a new conversion about every 5 ms
// - on-chip result is 16-bit read-only, D15 is a general alert flag
// - on-chip result bits D14 to D11 always read zero
// - D10 weighs -256 degrees, halving down to 0.25 degrees at D0
// - writes to 0x01..0x04 set output levels A..D; reads return results (0x01 reads zero here)
// - output-level write keeps D11:D0 as code, drops D15:D12
// - three alert status registers, 8 bits each, read and write
// - an alert event sets its matching status bit for the host
// - writing FF to an alert status register clears all its bits
// - writing one to a status bit clears only that bit
// - configuration D1 and D2 both set clears all alerts, enables pin
// - voltage alerts: even bit low, odd bit high, inputs 0 to 3
// - current alerts: monitor 1 at D1:D0, 2 at D3:D2, overrange D5:D4
// - temperature alerts: three low/high pairs, overtemp D6, open diode D7
// - channel select: D3:D0 analog inputs, D5:D4 current monitors
// - configuration register is 16-bit read/write, 0x0000 at power-up
// - source tag 110 marks remote sensor one, 111 remote sensor two

package mra_pkg;

	localparam logic [7:0] ADDR_RESULT_OR_LEVEL_A = 8'h01;
	localparam logic [7:0] ADDR_REMOTE_ONE_OR_B   = 8'h02;
	localparam logic [7:0] ADDR_REMOTE_TWO_OR_C   = 8'h03;
	localparam logic [7:0] ADDR_ONCHIP_OR_D       = 8'h04;
	localparam logic [7:0] ADDR_VOLTAGE_ALERT     = 8'h05;
	localparam logic [7:0] ADDR_CURRENT_ALERT     = 8'h06;
	localparam logic [7:0] ADDR_TEMP_ALERT        = 8'h07;
	localparam logic [7:0] ADDR_CHANNEL_SELECT    = 8'h08;
	localparam logic [7:0] ADDR_SETUP             = 8'h09;

	localparam logic [2:0]  TAG_REMOTE_ONE  = 3'h6;
	localparam logic [2:0]  TAG_REMOTE_TWO  = 3'h7;
	localparam logic [15:0] SETUP_RESET     = 16'h0000;
	localparam int          SETUP_ALERT_PIN = 2;
	localparam int          SETUP_CLEAR_ALL = 1;
	localparam logic [7:0]  VOLT_ALERT_MASK = 8'hFF;
	localparam logic [7:0]  CURR_ALERT_MASK = 8'h3F;
	localparam logic [7:0]  TEMP_ALERT_MASK = 8'hFF;
	localparam logic [7:0]  CHAN_SEL_MASK   = 8'h3F;
	localparam int          LEVEL_BITS      = 12;
	localparam int          TEMP_BITS       = 11;

	// temperature alert field positions
	localparam int TEMP_ALERT_REMOTE_ONE = 0;
	localparam int TEMP_ALERT_REMOTE_TWO = 2;
	localparam int TEMP_ALERT_ONCHIP     = 4;
	localparam int TEMP_ALERT_OVERTEMP   = 6;
	localparam int TEMP_ALERT_OPEN_DIODE = 7;

	localparam int unsigned CLK_HZ         = 25_000_000;
	localparam int unsigned CONV_PERIOD_US = 5000;
	localparam int unsigned CONV_CYCLES    =
		(CLK_HZ / 1_000_000) * CONV_PERIOD_US;

	typedef struct packed {
		logic [TEMP_BITS-1:0] remote_temp_one;
		logic [TEMP_BITS-1:0] remote_temp_two;
		logic [TEMP_BITS-1:0] onchip_temp;
		logic                 remote_one_open;
		logic                 remote_two_open;
	} mra_sample_t;

	typedef struct packed {
		logic [7:0] voltage;
		logic [5:0] current;
		logic [7:0] temperature;
	} mra_alert_evt_t;

	typedef struct packed {
		logic [LEVEL_BITS-1:0] level_a;
		logic [LEVEL_BITS-1:0] level_b;
		logic [LEVEL_BITS-1:0] level_c;
		logic [LEVEL_BITS-1:0] level_d;
	} mra_levels_t;

	typedef enum logic [1:0] {
		PHASE_HIGH = 2'b01,
		PHASE_LOW  = 2'b10
	} mra_phase_t;

endpackage : mra_pkg

// ===== mra_regs.sv
// register bank: temperature results, output levels, alert status, channel
// select and setup word, reached through a byte-wide register port.
// assumes a serial bus front end on the same clock delivering byte strobes.
`timescale 1ns/1ps

module mra_regs #(
	parameter int unsigned CONV_CYCLES = mra_pkg::CONV_CYCLES
) (
	input  wire logic                  clk_sys_in,
	input  wire logic                  resetn_in,
	input  wire logic                  xfer_start_in,
	input  wire logic [7:0]            reg_addr_in,
	input  wire logic                  wr_byte_valid_in,
	input  wire logic [7:0]            wr_byte_in,
	input  wire logic                  rd_byte_req_in,
	output logic      [7:0]            rd_byte_out,
	output logic                       rd_byte_valid_out,
	output logic                       conv_start_out,
	input  wire mra_pkg::mra_sample_t  sample_in,
	input  wire mra_pkg::mra_alert_evt_t alert_evt_in,
	output mra_pkg::mra_levels_t       levels_out,
	output logic      [7:0]            channel_select_out,
	output logic      [15:0]           setup_out,
	output logic                       alert_pin_enable_out
);

	// refused at elaboration: the counter needs a last count apart from zero
	if (CONV_CYCLES < 2) begin : g_conv_cycles_check
		$error("CONV_CYCLES must be at least 2");
	end

	logic                 rst_meta_n;
	logic                 rst_n;
	logic [7:0]           cur_addr;
	mra_pkg::mra_phase_t  phase;
	logic [7:0]           wr_hold;
	logic [7:0]           rd_hold;
	logic [31:0]          conv_count;
	logic                 conv_tick;
	logic [15:0]          remote_one_word;
	logic [15:0]          remote_two_word;
	logic [15:0]          onchip_word;
	logic [mra_pkg::TEMP_BITS-1:0] remote_one_temp;
	logic [mra_pkg::TEMP_BITS-1:0] remote_two_temp;
	logic [mra_pkg::TEMP_BITS-1:0] onchip_temp;
	logic                 remote_one_open;
	logic                 remote_two_open;
	logic [7:0]           voltage_alert_status;
	logic [7:0]           current_alert_status;
	logic [7:0]           temperature_alert_status;
	logic [7:0]           autocycle_channel_select;
	logic [15:0]          operating_setup;
	logic                 byte_wr;
	logic                 word_commit;
	logic [15:0]          word_data;
	logic                 clear_all;
	logic [15:0]          rd_word;
	logic [7:0]           next_rd_byte;
	logic [7:0]           voltage_evt;
	logic [7:0]           current_evt;
	logic [7:0]           temp_evt;

	// one status register update: set wins over the clear in the same cycle
	function automatic logic [7:0] alert_update(
		input logic [7:0] cur,
		input logic [7:0] set,
		input logic [7:0] clr,
		input logic [7:0] mask
	);
		alert_update = ((cur & ~clr) | set) & mask;
	endfunction : alert_update

	function automatic logic is_word_reg(input logic [7:0] addr);
		is_word_reg = (addr >= mra_pkg::ADDR_RESULT_OR_LEVEL_A &&
			addr <= mra_pkg::ADDR_ONCHIP_OR_D) ||
			addr == mra_pkg::ADDR_SETUP;
	endfunction : is_word_reg

	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rst_meta_n <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_meta_n <= 1'b1;
			rst_n      <= rst_meta_n;
		end
	end

	// conversion pacing: the results refresh on their own, no host needed
	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			conv_count <= 32'h0000_0000;
		end else if (conv_count == 32'(CONV_CYCLES - 1)) begin
			conv_count <= 32'h0000_0000;
		end else begin
			conv_count <= conv_count + 32'h0000_0001;
		end
	end

	assign conv_tick      = (conv_count == 32'(CONV_CYCLES - 1));
	assign conv_start_out = conv_tick;

	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			remote_one_temp <= '0;
			remote_two_temp <= '0;
			onchip_temp     <= '0;
			remote_one_open <= 1'b0;
			remote_two_open <= 1'b0;
		end else if (conv_tick) begin
			remote_one_temp <= sample_in.remote_temp_one;
			remote_two_temp <= sample_in.remote_temp_two;
			onchip_temp     <= sample_in.onchip_temp;
			remote_one_open <= sample_in.remote_one_open;
			remote_two_open <= sample_in.remote_two_open;
		end
	end

	// result words; temperature is kept as raw two's complement, D0 = 0.25
	// degrees and D10 = -256 degrees, so no scaling happens here
	assign remote_one_word = {
		|temperature_alert_status[mra_pkg::TEMP_ALERT_REMOTE_ONE +: 2],
		mra_pkg::TAG_REMOTE_ONE,
		remote_one_open,
		remote_one_temp
	};
	assign remote_two_word = {
		|temperature_alert_status[mra_pkg::TEMP_ALERT_REMOTE_TWO +: 2],
		mra_pkg::TAG_REMOTE_TWO,
		remote_two_open,
		remote_two_temp
	};
	assign onchip_word = {
		|{voltage_alert_status, current_alert_status,
			temperature_alert_status},
		4'h0,
		onchip_temp
	};

	// byte phase: 16-bit registers move high byte first, then low byte
	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			cur_addr <= 8'h00;
			phase    <= mra_pkg::PHASE_HIGH;
		end else if (xfer_start_in) begin
			cur_addr <= reg_addr_in;
			phase    <= mra_pkg::PHASE_HIGH;
		end else if ((wr_byte_valid_in || rd_byte_req_in) &&
				is_word_reg(cur_addr)) begin
			unique case (phase)
				mra_pkg::PHASE_HIGH: begin
					phase <= mra_pkg::PHASE_LOW;
				end
				mra_pkg::PHASE_LOW: begin
					phase <= mra_pkg::PHASE_HIGH;
				end
				default: begin
					phase <= mra_pkg::PHASE_HIGH;
				end
			endcase
		end
	end

	assign byte_wr     = wr_byte_valid_in && !xfer_start_in;
	assign word_commit = byte_wr && is_word_reg(cur_addr) &&
		phase == mra_pkg::PHASE_LOW;
	assign word_data   = {wr_hold, wr_byte_in};

	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			wr_hold <= 8'h00;
		end else if (byte_wr && phase == mra_pkg::PHASE_HIGH) begin
			wr_hold <= wr_byte_in;
		end
	end

	// output levels are write-only; reads at 0x02..0x04 see results, 0x01 reads zero
	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			levels_out <= '0;
		end else if (word_commit) begin
			unique case (cur_addr)
				mra_pkg::ADDR_RESULT_OR_LEVEL_A:
					levels_out.level_a <= word_data[11:0];
				mra_pkg::ADDR_REMOTE_ONE_OR_B:
					levels_out.level_b <= word_data[11:0];
				mra_pkg::ADDR_REMOTE_TWO_OR_C:
					levels_out.level_c <= word_data[11:0];
				mra_pkg::ADDR_ONCHIP_OR_D:
					levels_out.level_d <= word_data[11:0];
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			operating_setup <= mra_pkg::SETUP_RESET;
		end else if (word_commit && cur_addr == mra_pkg::ADDR_SETUP) begin
			operating_setup <= word_data;
		end
	end

	// clear-all fires on the write that lands both bits set
	assign clear_all = word_commit && cur_addr == mra_pkg::ADDR_SETUP &&
		word_data[mra_pkg::SETUP_ALERT_PIN] &&
		word_data[mra_pkg::SETUP_CLEAR_ALL];

	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			autocycle_channel_select <= 8'h00;
		end else if (byte_wr && cur_addr == mra_pkg::ADDR_CHANNEL_SELECT) begin
			autocycle_channel_select <=
				wr_byte_in & mra_pkg::CHAN_SEL_MASK;
		end
	end

	// events arrive as one-cycle pulses from the limit comparators
	assign voltage_evt = alert_evt_in.voltage;
	assign current_evt = {2'h0, alert_evt_in.current};
	assign temp_evt    = alert_evt_in.temperature;

	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			voltage_alert_status     <= 8'h00;
			current_alert_status     <= 8'h00;
			temperature_alert_status <= 8'h00;
		end else begin
			voltage_alert_status <= alert_update(voltage_alert_status,
				voltage_evt,
				clear_all ? 8'hFF :
				(byte_wr && cur_addr == mra_pkg::ADDR_VOLTAGE_ALERT) ?
				wr_byte_in : 8'h00,
				mra_pkg::VOLT_ALERT_MASK);
			current_alert_status <= alert_update(current_alert_status,
				current_evt,
				clear_all ? 8'hFF :
				(byte_wr && cur_addr == mra_pkg::ADDR_CURRENT_ALERT) ?
				wr_byte_in : 8'h00,
				mra_pkg::CURR_ALERT_MASK);
			temperature_alert_status <= alert_update(
				temperature_alert_status,
				temp_evt,
				clear_all ? 8'hFF :
				(byte_wr && cur_addr == mra_pkg::ADDR_TEMP_ALERT) ?
				wr_byte_in : 8'h00,
				mra_pkg::TEMP_ALERT_MASK);
		end
	end

	// read mux; offset 0x01 result belongs to the converter, reads zero here
	always_comb begin
		rd_word = 16'h0000;
		unique case (cur_addr)
			mra_pkg::ADDR_REMOTE_ONE_OR_B: rd_word = remote_one_word;
			mra_pkg::ADDR_REMOTE_TWO_OR_C: rd_word = remote_two_word;
			mra_pkg::ADDR_ONCHIP_OR_D:     rd_word = onchip_word;
			mra_pkg::ADDR_VOLTAGE_ALERT:
				rd_word = {8'h00, voltage_alert_status};
			mra_pkg::ADDR_CURRENT_ALERT:
				rd_word = {8'h00, current_alert_status};
			mra_pkg::ADDR_TEMP_ALERT:
				rd_word = {8'h00, temperature_alert_status};
			mra_pkg::ADDR_CHANNEL_SELECT:
				rd_word = {8'h00, autocycle_channel_select};
			mra_pkg::ADDR_SETUP:           rd_word = operating_setup;
			default:                       rd_word = 16'h0000;
		endcase
	end

	// the low byte is frozen when the high byte goes out, so a refresh
	// between the two bytes cannot tear the word
	always_comb begin
		next_rd_byte = rd_word[7:0];
		if (is_word_reg(cur_addr)) begin
			next_rd_byte = (phase == mra_pkg::PHASE_HIGH) ?
				rd_word[15:8] : rd_hold;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			rd_hold <= 8'h00;
		end else if (rd_byte_req_in && !xfer_start_in &&
				phase == mra_pkg::PHASE_HIGH) begin
			rd_hold <= rd_word[7:0];
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			rd_byte_out       <= 8'h00;
			rd_byte_valid_out <= 1'b0;
		end else begin
			rd_byte_valid_out <= rd_byte_req_in && !xfer_start_in;
			if (rd_byte_req_in && !xfer_start_in) begin
				rd_byte_out <= next_rd_byte;
			end
		end
	end

	assign channel_select_out   = autocycle_channel_select;
	assign setup_out            = operating_setup;
	assign alert_pin_enable_out = operating_setup[mra_pkg::SETUP_ALERT_PIN];

endmodule : mra_regs

// ===== mra_regs_checker_assertions.sv
// concurrent checks on the register bank ports, attached by bind.
// assumes one clock and an active-low reset taken as the disable.
`timescale 1ns/1ps

module mra_regs_checker #(
	parameter int unsigned CONV_CYCLES = mra_pkg::CONV_CYCLES
) (
	input wire logic                 clk_sys_in,
	input wire logic                 resetn_in,
	input wire logic                 xfer_start_in,
	input wire logic                 wr_byte_valid_in,
	input wire logic                 rd_byte_req_in,
	input wire logic [7:0]           rd_byte_out,
	input wire logic                 rd_byte_valid_out,
	input wire logic                 conv_start_out,
	input wire mra_pkg::mra_levels_t levels_out,
	input wire logic [7:0]           channel_select_out,
	input wire logic [15:0]          setup_out,
	input wire logic                 alert_pin_enable_out
);
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!resetn_in);

	// the first pulse after reset has no earlier pulse to measure from
	int unsigned gap;
	logic        seen;
	always_ff @(posedge clk_sys_in or negedge resetn_in) begin
		if (!resetn_in) begin
			gap <= 0;
			seen <= 1'b0;
		end else if (conv_start_out) begin
			gap <= 0;
			seen <= 1'b1;
		end else begin
			gap <= gap + 1;
		end
	end

	chk_conv_period: assert property ((conv_start_out && seen) |->
		gap == CONV_CYCLES - 1) else $error("conversion spacing wrong");
	chk_rd_answer: assert property ((rd_byte_req_in && !xfer_start_in)
		|=> rd_byte_valid_out) else $error("read byte not answered");
	chk_rd_cause: assert property (rd_byte_valid_out |->
		$past(rd_byte_req_in)) else $error("read valid without request");
	chk_rd_hold: assert property ($changed(rd_byte_out) |->
		rd_byte_valid_out) else $error("read byte changed unannounced");
	chk_level_write: assert property ($changed(levels_out) |->
		$past(wr_byte_valid_in)) else $error("level moved without write");
	chk_setup_write: assert property ($changed(setup_out) |->
		$past(wr_byte_valid_in)) else $error("setup moved without write");
	chk_chan_write: assert property ($changed(channel_select_out) |->
		$past(wr_byte_valid_in)) else $error("select moved without write");
	chk_chan_reserved: assert property (
		channel_select_out[7:6] == 2'b00) else $error("reserved select set");
	chk_pin_enable: assert property (
		alert_pin_enable_out == setup_out[mra_pkg::SETUP_ALERT_PIN])
		else $error("pin enable wrong");

	cover property (conv_start_out && seen);
	cover property (rd_byte_valid_out);
	cover property ($changed(levels_out));
	cover property (alert_pin_enable_out);
endmodule : mra_regs_checker

bind mra_regs mra_regs_checker #(.CONV_CYCLES(CONV_CYCLES)) u_chk (
	.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
	.xfer_start_in(xfer_start_in), .wr_byte_valid_in(wr_byte_valid_in),
	.rd_byte_req_in(rd_byte_req_in), .rd_byte_out(rd_byte_out),
	.rd_byte_valid_out(rd_byte_valid_out), .conv_start_out(conv_start_out),
	.levels_out(levels_out), .channel_select_out(channel_select_out),
	.setup_out(setup_out), .alert_pin_enable_out(alert_pin_enable_out));
